/* File: rtl/ssa_params.svh */
// constants for the smi status aggregator: offsets, bit positions, counts
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH

// i/o offsets inside the smi status window
`define SSA_OFF_TOP_MIRROR 8'h00
`define SSA_OFF_TOP_CLEAR  8'h02
`define SSA_OFF_TT_MIRROR  8'h04
`define SSA_OFF_TT_CLEAR   8'h06
`define SSA_OFF_SPEEDUP    8'h08
`define SSA_OFF_RSVD_LO    8'h0A
`define SSA_OFF_RSVD_HI    8'h1B
`define SSA_OFF_PM_TIMER   8'h1C
`define SSA_OFF_EXT_CLEAR  8'h24
`define SSA_OFF_EXT_MIRROR 8'h25

// top-level status bit positions
`define SSA_B_SUSP  15
`define SSA_B_USB   14
`define SSA_B_WARM  13
`define SSA_B_NMI   12
`define SSA_B_IRQ2  11
`define SSA_B_EXT   10
`define SSA_B_TT    9
`define SSA_B_SW    8
`define SSA_B_A20   7
`define SSA_B_VGA   6
`define SSA_B_VID   5
`define SSA_B_RSVD  4
`define SSA_B_LPC   3
`define SSA_B_ACPI  2
`define SSA_B_AUDIO 1
`define SSA_B_PM    0

// masks and reset values
`define SSA_TOP_RC_MASK  16'hF9E0
`define SSA_TOP_REQ_MASK 16'h7FFF
`define SSA_RST_16       16'h0000
`define SSA_RST_8        8'h00
`define SSA_SYNC_IDLE    8'hFF

// widths and counts
`define SSA_TT_W       6
`define SSA_EXT_W      8
`define SSA_PMT_W      24
`define SSA_VID_BIT    7
`define SSA_PM_TICK_DIV 70

`endif

/* File: rtl/ssa_pkg.sv */
// types shared by the smi status aggregator files
package ssa_pkg;

	// one-hot register select decoded from the i/o offset
	typedef enum logic [7:0] {
		SSA_SEL_NONE  = 8'h00,
		SSA_SEL_TOPM  = 8'h01,
		SSA_SEL_TOPC  = 8'h02,
		SSA_SEL_TTM   = 8'h04,
		SSA_SEL_TTC   = 8'h08,
		SSA_SEL_SPD   = 8'h10,
		SSA_SEL_PMT   = 8'h20,
		SSA_SEL_EXTC  = 8'h40,
		SSA_SEL_EXTM  = 8'h80
	} ssa_sel_e;

endpackage : ssa_pkg

/* File: rtl/ssa_pmt_if.sv */
// carrier between the aggregator and its power-management timer
`timescale 1ns/1ps
`default_nettype none
interface ssa_pmt_if #(parameter int W = 24);
	logic [W-1:0] count;
	logic         tick;
	modport timer (output count, output tick);
	modport user  (input count, input tick);
endinterface : ssa_pmt_if
`default_nettype wire

/* File: rtl/ssa_pm_timer.sv */
// free-running power-management timer with prescaler
`timescale 1ns/1ps
`default_nettype none
`include "ssa_params.svh"
module ssa_pm_timer
	import ssa_pkg::*;
#(
	parameter int DIV = `SSA_PM_TICK_DIV,
	parameter int W   = `SSA_PMT_W
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// timer value out
	ssa_pmt_if.timer  pmt
);
	logic [7:0]   pre_q;
	logic [W-1:0] cnt_q;
	wire          wrap = (pre_q == 8'(DIV - 1));

	// prescaler and running count, wraps silently
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pre_q <= 8'h00;
			cnt_q <= '0;
		end else begin
			pre_q <= wrap ? 8'h00 : pre_q + 8'h01;
			if (wrap)
				cnt_q <= cnt_q + W'(1);
		end
	end

	assign pmt.count = cnt_q;
	assign pmt.tick  = wrap;

	// count moves only on a prescaler wrap
	chk_pmt_advance : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!wrap |=> cnt_q == $past(cnt_q))
		else $error("pm timer moved without a tick");
endmodule : ssa_pm_timer
`default_nettype wire

/* File: rtl/ssa_status_aggregator.sv */
// smi status aggregator: top-level and second-level status, strobes, timer
`timescale 1ns/1ps
`default_nettype none
`include "ssa_params.svh"
module ssa_status_aggregator
	import ssa_pkg::*;
#(
	parameter int PM_DIV = `SSA_PM_TICK_DIV
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// i/o cycles through the window
	input  wire logic        io_rd_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_acpi_space_i,
	input  wire logic [7:0]  io_addr_i,
	input  wire logic [31:0] io_wdata_i,
	output logic      [31:0] io_rdata_o,
	output logic             io_ack_o,
	// configuration bits from function 0
	input  wire logic [1:0]  cfg_suspend_i,
	input  wire logic        cfg_a20_en_i,
	input  wire logic [3:0]  cfg_tmr_vid_en_i,
	input  wire logic [2:0]  cfg_user_trap_en_i,
	input  wire logic [5:0]  cfg_func_trap_en_i,
	// event pulses from sources
	input  wire logic        usb_evt_i,
	input  wire logic        warm_reset_evt_i,
	input  wire logic        nmi_evt_i,
	input  wire logic        super_io_block_irq2_i,
	input  wire logic        sw_smi_evt_i,
	input  wire logic        address_bit20_mask_evt_i,
	input  wire logic        vga_timer_evt_i,
	input  wire logic [7:0]  internal_serial_status_i,
	input  wire logic [1:0]  gp_timer_evt_i,
	input  wire logic [2:0]  user_trap_evt_i,
	input  wire logic [5:0]  func_trap_evt_i,
	// second-level summaries kept elsewhere
	input  wire logic        lpc_smi_i,
	input  wire logic        acpi_smi_i,
	input  wire logic        audio_smi_i,
	input  wire logic        pm_smi_i,
	// external smi pins, asynchronous
	input  wire logic [7:0]  external_smi_inputs_i,
	// smi request and strobes
	output logic             smi_req_o,
	output logic             speedup_smi_o
);
	logic [15:0]           top_q;
	logic [`SSA_TT_W-1:0]  tt_q;
	logic [`SSA_EXT_W-1:0] ext_q, ext_en_q;
	logic [`SSA_EXT_W-1:0] ext_s1_q, ext_s2_q, ext_s3_q;
	logic                  vid_prev_q;
	logic                  smi_q, spd_q, ack_q;
	logic [31:0]           rdata_q;

	ssa_pmt_if #(.W(`SSA_PMT_W)) pmt ();

	// timer instance
	ssa_pm_timer #(.DIV(PM_DIV), .W(`SSA_PMT_W)) u_timer (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.pmt       (pmt.timer)
	);

	// select a register from space and offset
	function automatic ssa_sel_e decode(input logic acpi, input logic [7:0] a);
		if (acpi)
			decode = (a == `SSA_OFF_PM_TIMER) ? SSA_SEL_PMT : SSA_SEL_NONE;
		else begin
			case (a)
				`SSA_OFF_TOP_MIRROR: decode = SSA_SEL_TOPM;
				`SSA_OFF_TOP_CLEAR:  decode = SSA_SEL_TOPC;
				`SSA_OFF_TT_MIRROR:  decode = SSA_SEL_TTM;
				`SSA_OFF_TT_CLEAR:   decode = SSA_SEL_TTC;
				`SSA_OFF_SPEEDUP:    decode = SSA_SEL_SPD;
				`SSA_OFF_PM_TIMER:   decode = SSA_SEL_PMT;
				`SSA_OFF_EXT_CLEAR:  decode = SSA_SEL_EXTC;
				`SSA_OFF_EXT_MIRROR: decode = SSA_SEL_EXTM;
				default:             decode = SSA_SEL_NONE;
			endcase
		end
	endfunction : decode

	// access decode
	wire ssa_sel_e sel     = decode(io_acpi_space_i, io_addr_i);
	wire           rd_topc = io_rd_i && sel == SSA_SEL_TOPC;
	wire           rd_ttc  = io_rd_i && sel == SSA_SEL_TTC;
	wire           rd_extc = io_rd_i && sel == SSA_SEL_EXTC;
	wire           rd_spd  = io_rd_i && sel == SSA_SEL_SPD;
	wire           wr_ext  = io_wr_i && sel == SSA_SEL_EXTC;

	// event detection
	wire vid_rise = internal_serial_status_i[`SSA_VID_BIT] && !vid_prev_q;
	wire [`SSA_EXT_W-1:0] ext_fall = ext_s3_q & ~ext_s2_q & ext_en_q;

	// second-level timers and traps set vector
	wire [`SSA_TT_W-1:0] tt_set = {
		|(func_trap_evt_i & cfg_func_trap_en_i),
		user_trap_evt_i & cfg_user_trap_en_i,
		gp_timer_evt_i & cfg_tmr_vid_en_i[1:0]
	};

	// top-level read-to-clear set vector
	logic [15:0] top_set;
	always_comb begin
		top_set = `SSA_RST_16;
		top_set[`SSA_B_SUSP] = cfg_suspend_i[0];
		top_set[`SSA_B_USB]  = usb_evt_i;
		top_set[`SSA_B_WARM] = warm_reset_evt_i;
		top_set[`SSA_B_NMI]  = nmi_evt_i;
		top_set[`SSA_B_IRQ2] = super_io_block_irq2_i;
		top_set[`SSA_B_SW]   = sw_smi_evt_i;
		top_set[`SSA_B_A20]  = address_bit20_mask_evt_i && cfg_a20_en_i;
		top_set[`SSA_B_VGA]  = vga_timer_evt_i && cfg_tmr_vid_en_i[3];
		top_set[`SSA_B_VID]  = vid_rise && cfg_tmr_vid_en_i[2];
	end

	// next state, set wins over a read clear
	wire [15:0] top_clr = rd_topc ? `SSA_TOP_RC_MASK : `SSA_RST_16;
	wire [15:0] top_d = ((top_q & ~top_clr) | top_set) & `SSA_TOP_RC_MASK;
	wire [`SSA_TT_W-1:0] tt_d = (rd_ttc ? '0 : tt_q) | tt_set;
	wire [`SSA_EXT_W-1:0] ext_d = (rd_extc ? '0 : ext_q) | ext_fall;

	// top view with summaries, bit 4 held at zero
	logic [15:0] top_view;
	always_comb begin
		top_view = top_q;
		top_view[`SSA_B_EXT]   = |ext_q;
		top_view[`SSA_B_TT]    = |tt_q;
		top_view[`SSA_B_RSVD]  = 1'b0;
		top_view[`SSA_B_LPC]   = lpc_smi_i;
		top_view[`SSA_B_ACPI]  = acpi_smi_i;
		top_view[`SSA_B_AUDIO] = audio_smi_i;
		top_view[`SSA_B_PM]    = pm_smi_i;
	end

	// request covers every source bit, not the suspend mirror
	wire req_any = |(top_view & `SSA_TOP_REQ_MASK);

	// read data selection
	logic [31:0] rd_mux;
	always_comb begin
		case (sel)
			SSA_SEL_TOPM, SSA_SEL_TOPC: rd_mux = {16'h0000, top_view};
			SSA_SEL_TTM, SSA_SEL_TTC:   rd_mux = 32'({tt_q});
			SSA_SEL_SPD:                rd_mux = 32'h0000_0000;
			SSA_SEL_PMT:                rd_mux = 32'(pmt.count);
			SSA_SEL_EXTC, SSA_SEL_EXTM: rd_mux = {8'h00, ext_q, ext_q, ext_en_q};
			default:                    rd_mux = 32'h0000_0000;
		endcase
	end

	// external pin synchroniser, idle high so reset makes no edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ext_s1_q <= `SSA_SYNC_IDLE;
			ext_s2_q <= `SSA_SYNC_IDLE;
			ext_s3_q <= `SSA_SYNC_IDLE;
		end else begin
			ext_s1_q <= external_smi_inputs_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// status registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			top_q      <= `SSA_RST_16;
			tt_q       <= '0;
			ext_q      <= `SSA_RST_8;
			vid_prev_q <= 1'b0;
		end else begin
			top_q      <= top_d;
			tt_q       <= tt_d;
			ext_q      <= ext_d;
			vid_prev_q <= internal_serial_status_i[`SSA_VID_BIT];
		end
	end

	// external enable register, the only writable field
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			ext_en_q <= `SSA_RST_8;
		else if (wr_ext)
			ext_en_q <= io_wdata_i[`SSA_EXT_W-1:0];
	end

	// answer, request and strobe outputs
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
			ack_q   <= 1'b0;
			smi_q   <= 1'b0;
			spd_q   <= 1'b0;
		end else begin
			if (io_rd_i)
				rdata_q <= rd_mux;
			ack_q <= io_rd_i || io_wr_i;
			smi_q <= req_any;
			spd_q <= rd_spd && cfg_suspend_i[1];
		end
	end

	assign io_rdata_o    = rdata_q;
	assign io_ack_o      = ack_q;
	assign smi_req_o     = smi_q;
	assign speedup_smi_o = spd_q;

	// clearing read empties every read-to-clear bit not set again
	chk_top_rc_clear : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_topc |=> (top_q & `SSA_TOP_RC_MASK & ~$past(top_set)) == 16'h0000)
		else $error("top read did not clear status");

	// mirror read changes nothing
	chk_top_mirror_keep : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		io_rd_i && sel == SSA_SEL_TOPM |=> top_q == ($past(top_q) | $past(top_set)))
		else $error("top mirror read altered status");

	// bit 4 reads zero on every top read answer
	chk_bit4_zero : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		io_rd_i && (sel == SSA_SEL_TOPM || sel == SSA_SEL_TOPC)
		|=> io_ack_o && !io_rdata_o[`SSA_B_RSVD])
		else $error("reserved top bit read nonzero");

	// summary bit 9 survives a top clearing read
	chk_summary_hold : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_topc && !rd_ttc && |tt_q |=> top_view[`SSA_B_TT])
		else $error("summary bit cleared by top read");

	// timers and traps mirror read keeps its bits
	chk_tt_mirror_keep : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		io_rd_i && sel == SSA_SEL_TTM |=> tt_q == ($past(tt_q) | $past(tt_set)))
		else $error("timers mirror read altered status");

	// clearing read empties second level and the summary
	chk_tt_clear : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_ttc && tt_set == '0 |=> tt_q == '0 && !top_view[`SSA_B_TT])
		else $error("timers clearing read left status");

	// enabled falling edge raises bit 10 next cycle
	chk_ext_edge : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ext_fall != '0 |=> top_view[`SSA_B_EXT] && (ext_q & $past(ext_fall)) != '0)
		else $error("external edge not recorded");

	// suspend mirror follows configuration
	chk_susp_mirror : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cfg_suspend_i[0] |=> top_q[`SSA_B_SUSP])
		else $error("suspend mirror bit not set");

	// request tracks pending sources one cycle later
	chk_smi_req : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		##1 smi_req_o == $past(req_any))
		else $error("smi request does not track status");

	// speedup strobe only with suspend modulation enabled
	chk_speedup : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		rd_spd |=> speedup_smi_o == $past(cfg_suspend_i[1])
		##1 (!speedup_smi_o || $past(rd_spd)))
		else $error("speedup strobe wrong");

	// timer read returns the count, top byte zero
	chk_pmt_read : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		io_rd_i && sel == SSA_SEL_PMT |=> io_rdata_o == {8'h00, $past(pmt.count)})
		else $error("timer read value wrong");

	// vga source stays quiet when its enable is off
	chk_vga_gate : assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!top_q[`SSA_B_VGA] && !cfg_tmr_vid_en_i[3] |=> !top_q[`SSA_B_VGA])
		else $error("vga bit set while disabled");
endmodule : ssa_status_aggregator
`default_nettype wire

/* File: verification/ssa_core_model.sv */
// processor-side model issuing smi handler i/o cycles
`timescale 1ns/1ps
`default_nettype none
module ssa_core_model (
	// clock and answer
	input  wire logic        clk_sys_i,
	input  wire logic        io_ack_i,
	input  wire logic [31:0] io_rdata_i,
	// request towards the window
	output var  logic        io_rd_o,
	output var  logic        io_wr_o,
	output var  logic        io_acpi_space_o,
	output var  logic [7:0]  io_addr_o,
	output var  logic [31:0] io_wdata_o
);
	// idle bus before the first access
	initial begin
		io_rd_o = 1'b0;
		io_wr_o = 1'b0;
		io_acpi_space_o = 1'b0;
		io_addr_o = 8'hFF;
		io_wdata_o = 32'h0;
	end

	// one access: strobe for one cycle, address held until ack
	task automatic xfer(input logic w, input logic sp, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		#1;
		io_rd_o = !w;
		io_wr_o = w;
		io_acpi_space_o = sp;
		io_addr_o = a;
		io_wdata_o = wd;
		@(posedge clk_sys_i);
		#1;
		io_rd_o = 1'b0;
		io_wr_o = 1'b0;
		while (io_ack_i !== 1'b1 && n < 4) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		rd = io_rdata_i;
		// released lines show no stale value
		io_addr_o = ~a;
		io_wdata_o = ~wd;
	endtask : xfer
endmodule : ssa_core_model
`default_nettype wire

/* File: verification/smi_status_aggregator_tb.sv */
// self-checking bench for the smi status aggregator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin \
	n_errors++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
	end end
module smi_status_aggregator_tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        io_rd, io_wr, io_sp, io_ack, smi_req, speedup;
	logic [7:0]  io_addr, ev, pins, m;
	logic [31:0] io_wdata, io_rdata, d, d2, a;
	logic [1:0]  cfg_susp = 2'b00;
	logic        cfg_a20 = 1'b1;
	logic [3:0]  cfg_tv = 4'hF;
	logic [2:0]  cfg_ut = 3'h0;
	logic [5:0]  cfg_ft = 6'h0;
	logic [5:0]  sl = 6'h0, sle;
	logic [3:0]  lv = 4'h0;
	logic [15:0] e;
	int          n_errors = 0, check_count = 0, k;
	int          pos[8] = '{14, 13, 12, 11, 8, 7, 6, 5};

	// clock and idle stimulus
	always #2 clk_sys_i = ~clk_sys_i;
	initial ev = 8'h00;
	initial pins = 8'hFF;

	ssa_core_model i_ssa_core_model (.clk_sys_i(clk_sys_i), .io_ack_i(io_ack),
		.io_rdata_i(io_rdata), .io_rd_o(io_rd), .io_wr_o(io_wr),
		.io_acpi_space_o(io_sp), .io_addr_o(io_addr), .io_wdata_o(io_wdata));

	ssa_status_aggregator #(.PM_DIV(2)) i_ssa_status_aggregator (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .io_rd_i(io_rd), .io_wr_i(io_wr),
		.io_acpi_space_i(io_sp), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
		.io_rdata_o(io_rdata), .io_ack_o(io_ack), .cfg_suspend_i(cfg_susp),
		.cfg_a20_en_i(cfg_a20), .cfg_tmr_vid_en_i(cfg_tv),
		.cfg_user_trap_en_i(cfg_ut), .cfg_func_trap_en_i(cfg_ft),
		.usb_evt_i(ev[0]), .warm_reset_evt_i(ev[1]), .nmi_evt_i(ev[2]),
		.super_io_block_irq2_i(ev[3]), .sw_smi_evt_i(ev[4]),
		.address_bit20_mask_evt_i(ev[5]), .vga_timer_evt_i(ev[6]),
		.internal_serial_status_i({ev[7], 7'h00}), .gp_timer_evt_i(sl[1:0]),
		.user_trap_evt_i(sl[4:2]), .func_trap_evt_i({6{sl[5]}}),
		.lpc_smi_i(lv[3]), .acpi_smi_i(lv[2]), .audio_smi_i(lv[1]),
		.pm_smi_i(lv[0]), .external_smi_inputs_i(pins), .smi_req_o(smi_req),
		.speedup_smi_o(speedup));

	// expected top bit for event source i, gated by its enable for sources 5 to 7 only
	function automatic logic [15:0] top_exp(int i, logic en);
		return (i >= 5 && !en) ? 16'h0000 : 16'h0001 << pos[i];
	endfunction : top_exp

	// bus helpers and settle delay
	task automatic rd(input logic sp, input logic [7:0] ad);
		i_ssa_core_model.xfer(1'b0, sp, ad, 32'h0, d);
	endtask : rd
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		i_ssa_core_model.xfer(1'b1, 1'b0, ad, v, d2);
	endtask : wr
	task automatic rdchk(string nm, logic sp, logic [7:0] ad, logic [31:0] ex);
		rd(sp, ad);
		`CHK(nm, ex, d)
	endtask : rdchk
	task automatic step(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step

	// verdict
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// watchdog
	initial begin
		#40000;
		n_errors++;
		test_done();
	end

	// main sequence
	initial begin
		void'($urandom(51437));
		step(2);
		rst_i = 1'b0;
		step(2);
		rdchk("tt_mirror_rst", 0, 8'h04, 32'h0);
		rdchk("tt_clear_rst", 0, 8'h06, 32'h0);
		rdchk("top_rst", 0, 8'h00, 32'h0);
		// single-source events, enabled then disabled (usb, warm reset, nmi, irq2 and sw have no enable)
		for (int r = 0; r < 2; r++) begin
			cfg_a20 = !r;
			cfg_tv = r ? 4'h0 : 4'hF;
			for (int i = 0; i < 8; i++) begin
				e = top_exp(i, !r);
				ev[i] = 1'b1;
				step(1);
				ev[i] = 1'b0;
				step(1);
				`CHK("smi_req_evt", |e, smi_req)
				rdchk("top_mirror", 0, 8'h00, {16'h0, e});
				rdchk("top_clear", 0, 8'h02, {16'h0, e});
				rdchk("top_after", 0, 8'h02, 32'h0);
			end
		end
		// second-level timers and traps with random enables
		for (int r = 0; r < 4; r++) begin
			cfg_tv = {2'b00, 2'($urandom)};
			cfg_ut = 3'($urandom);
			cfg_ft = 6'($urandom);
			if (r == 0) {cfg_tv, cfg_ut, cfg_ft} = 13'h1FFF;
			if (r == 1) {cfg_tv, cfg_ut, cfg_ft} = 13'h0000;
			sle = {|cfg_ft, cfg_ut, cfg_tv[1:0]};
			e = (|sle) ? 16'h0200 : 16'h0000;
			sl = 6'h3F;
			step(1);
			sl = 6'h00;
			rdchk("tt_mirror", 0, 8'h04, {26'h0, sle});
			rdchk("tt_mirror2", 0, 8'h04, {26'h0, sle});
			rdchk("top_tt", 0, 8'h02, {16'h0, e});
			rdchk("top_tt2", 0, 8'h00, {16'h0, e});
			rdchk("tt_clear", 0, 8'h06, {26'h0, sle});
			rdchk("tt_clear2", 0, 8'h06, 32'h0);
			rdchk("top_tt3", 0, 8'h00, 32'h0);
			`CHK("smi_req_idle", 1'b0, smi_req)
		end
		// live summaries and the reserved bit
		for (int r = 0; r < 3; r++) begin
			lv = (r == 0) ? 4'hF : 4'($urandom);
			step(2);
			rdchk("top_live", 0, 8'h02, {28'h0, lv});
			rdchk("top_live2", 0, 8'h00, {28'h0, lv});
			`CHK("smi_req_live", |lv, smi_req)
		end
		lv = 4'h0;
		// suspend mirror and speedup strobe
		cfg_susp = 2'b01;
		step(2);
		rdchk("top_susp", 0, 8'h00, 32'h8000);
		cfg_susp = 2'b00;
		rdchk("top_susp2", 0, 8'h02, 32'h8000);
		rdchk("top_susp3", 0, 8'h02, 32'h0);
		cfg_susp = 2'b10;
		rd(0, 8'h08);
		`CHK("speedup_on", 1'b1, speedup)
		step(1);
		`CHK("speedup_end", 1'b0, speedup)
		cfg_susp = 2'b00;
		rd(0, 8'h08);
		`CHK("speedup_off", 1'b0, speedup)
		// timer readout in both windows
		rd(0, 8'h1C);
		a = d;
		rd(1, 8'h1C);
		`CHK("tmr_rsvd", 8'h00, d[31:24])
		`CHK("tmr_step", 1'b1, (d[23:0] - a[23:0]) inside {1, 2})
		// write to the reserved gap is ignored
		wr(8'h0A, $urandom);
		rdchk("rsvd_gap", 0, 8'h0A, 32'h0);
		rdchk("top_gap", 0, 8'h00, 32'h0);
		// external pin falling edge
		wr(8'h24, 32'h0000_00FF);
		k = $urandom % 8;
		m = 8'h01 << k;
		pins[k] = 1'b0;
		step(8);
		rdchk("ext_mirror", 0, 8'h25, {8'h00, m, m, 8'hFF});
		rdchk("top_ext", 0, 8'h00, 32'h0400);
		rdchk("ext_clear", 0, 8'h24, {8'h00, m, m, 8'hFF});
		rdchk("ext_after", 0, 8'h25, 32'h0000_00FF);
		rdchk("top_ext2", 0, 8'h00, 32'h0);
		pins = 8'hFF;
		test_done();
	end
endmodule : smi_status_aggregator_tb
`default_nettype wire
